// File: rtl/sync_check_pkg.sv
/*
  Shared constants and carriers for the synchronism-check event recorder:
  stage count, condition codes, forced-status codes, record layout.
  Assumes every input comes from logic on the single 40 MHz system clock.
*/
package sync_check_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_STAGES   = 3;
  localparam int unsigned NUM_COND     = 8;
  localparam int unsigned NUM_EVT_SRC  = NUM_STAGES * NUM_COND;
  localparam int unsigned REC_DEPTH    = 12;
  localparam int unsigned TIME_W       = 48;
  localparam int unsigned MEAS_W       = 16;
  localparam int unsigned GROUP_W      = 3;
  localparam int unsigned FORCE_W      = 3;

  // ----------------------------------------------------------------------
  // Condition positions within a stage's flag vector
  // ----------------------------------------------------------------------
  localparam logic [2:0] COND_BLOCKED   = 3'h0;
  localparam logic [2:0] COND_OK        = 3'h1;
  localparam logic [2:0] COND_BYPASS    = 3'h2;
  localparam logic [2:0] COND_VOLT_COND = 3'h3;
  localparam logic [2:0] COND_VDIFF     = 3'h4;
  localparam logic [2:0] COND_ADIFF     = 3'h5;
  localparam logic [2:0] COND_FDIFF     = 3'h6;
  localparam logic [2:0] COND_SWITCH    = 3'h7;

  // ----------------------------------------------------------------------
  // Forced status codes
  // ----------------------------------------------------------------------
  localparam logic [FORCE_W-1:0] FORCE_NORMAL = 3'h0;
  localparam logic [FORCE_W-1:0] FORCE_MAX    = 3'h6;

  localparam logic [1:0] STAGE_NONE = 2'h3;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef logic [NUM_COND-1:0] stage_flags_t;

  typedef struct packed {
    logic [MEAS_W-1:0] first_ref_voltage;
    logic [MEAS_W-1:0] second_ref_voltage;
    logic [3:0]        voltage_state_condition;
    logic [3:0]        voltage_status;
    logic [MEAS_W-1:0] voltage_difference;
    logic [MEAS_W-1:0] voltage_difference_limit;
    logic [MEAS_W-1:0] angle_difference;
    logic [MEAS_W-1:0] angle_difference_limit;
    logic [MEAS_W-1:0] frequency_difference;
    logic [MEAS_W-1:0] frequency_difference_limit;
  } stage_data_t;

  typedef struct packed {
    logic [1:0] stage;
    logic [2:0] cond;
    logic       is_on;
  } event_id_t;

  typedef struct packed {
    logic [TIME_W-1:0]  time_ms;
    event_id_t          id;
    stage_data_t        data;
    logic [GROUP_W-1:0] setting_group;
  } event_record_t;

  localparam event_record_t RECORD_RESET = '0;

endpackage

// File: rtl/sync_check_event_recorder.sv
/*
  Event and record logic of the three-stage synchronism check.
  Detects edges on each stage's status and comparison flags, queues
  the selected ON/OFF events, emits one per cycle toward the main event
  buffer and keeps the latest operations in a circular record store.
  Assumes flags, measurements, time and settings are synchronous to
  i_clock and that the time counter counts milliseconds.
*/
`timescale 1ns/100ps
module sync_check_event_recorder #(
  parameter int unsigned NUM_RECORDS = sync_check_pkg::REC_DEPTH
) (
  input  wire logic                                 i_clock,
  input  wire logic                                 i_sys_rst,
  input  wire sync_check_pkg::stage_flags_t         i_stage_flags [sync_check_pkg::NUM_STAGES],
  input  wire sync_check_pkg::stage_data_t          i_stage_data  [sync_check_pkg::NUM_STAGES],
  input  wire logic                                 i_force_enable,
  input  wire logic [sync_check_pkg::FORCE_W-1:0]   i_force_status,
  input  wire logic [sync_check_pkg::NUM_EVT_SRC-1:0] i_on_select,
  input  wire logic [sync_check_pkg::NUM_EVT_SRC-1:0] i_off_select,
  input  wire logic [sync_check_pkg::TIME_W-1:0]    i_time_ms,
  input  wire logic [sync_check_pkg::GROUP_W-1:0]   i_setting_group,
  input  wire logic [3:0]                           i_read_index,
  output logic                                      o_event_valid,
  output sync_check_pkg::event_record_t             o_event,
  output sync_check_pkg::event_record_t             o_record,
  output logic                                      o_record_valid,
  output logic [3:0]                                o_record_count
);
  import sync_check_pkg::*;

  localparam int unsigned PTR_W  = $clog2(NUM_RECORDS);
  localparam int unsigned PEND_W = 2 * NUM_EVT_SRC;
  localparam int unsigned IDX_W  = $clog2(PEND_W);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Stage that a forced code addresses, or none
  function automatic logic [1:0] forced_stage(input logic [FORCE_W-1:0] code);
    logic [FORCE_W-1:0] off;
    off = code - 3'h1;
    if (code == FORCE_NORMAL || code > FORCE_MAX) begin
      forced_stage = STAGE_NONE;
    end else begin
      forced_stage = off[2:1];
    end
  endfunction

  // Lowest pending index, ON before OFF; fixed priority keeps arbitration cheap
  function automatic logic [IDX_W-1:0] first_set(input logic [PEND_W-1:0] vec);
    first_set = '0;
    for (int k = PEND_W - 1; k >= 0; k--) begin
      if (vec[k]) begin
        first_set = IDX_W'(k);
      end
    end
  endfunction

  function automatic logic [PTR_W-1:0] ptr_wrap(input logic [PTR_W:0] value);
    if (value >= (PTR_W+1)'(NUM_RECORDS)) begin
      ptr_wrap = PTR_W'(value - (PTR_W+1)'(NUM_RECORDS));
    end else begin
      ptr_wrap = value[PTR_W-1:0];
    end
  endfunction

  // Pending indices below the source count are ON requests
  function automatic logic pick_is_on(input logic [IDX_W-1:0] idx);
    pick_is_on = (idx < IDX_W'(NUM_EVT_SRC));
  endfunction

  // Source number of a pending index, whichever polarity it carries
  function automatic logic [4:0] pick_source(input logic [IDX_W-1:0] idx);
    if (pick_is_on(idx)) begin
      pick_source = 5'(idx);
    end else begin
      pick_source = 5'(idx - IDX_W'(NUM_EVT_SRC));
    end
  endfunction

  // ----------------------------------------------------------------------
  // Effective flags with forcing applied
  // ----------------------------------------------------------------------
  stage_flags_t eff_flags [NUM_STAGES];
  logic [1:0]   force_stage;

  always_comb begin
    force_stage = i_force_enable ? forced_stage(i_force_status) : STAGE_NONE;
    for (int s = 0; s < NUM_STAGES; s++) begin
      eff_flags[s] = i_stage_flags[s];
      if (force_stage == 2'(s)) begin
        // Odd codes force blocked, even codes force ok
        eff_flags[s][COND_BLOCKED] = i_force_status[0];
        eff_flags[s][COND_OK]      = ~i_force_status[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Edge detection and pending queue
  // ----------------------------------------------------------------------
  logic [NUM_EVT_SRC-1:0] prev_reg;
  logic [NUM_EVT_SRC-1:0] prev_next;
  logic [NUM_EVT_SRC-1:0] pend_on_reg;
  logic [NUM_EVT_SRC-1:0] pend_on_next;
  logic [NUM_EVT_SRC-1:0] pend_off_reg;
  logic [NUM_EVT_SRC-1:0] pend_off_next;
  logic [NUM_EVT_SRC-1:0] rise;
  logic [NUM_EVT_SRC-1:0] fall;
  logic [PEND_W-1:0]      pend_all;
  logic [IDX_W-1:0]       pick;
  logic                   emit;
  logic [NUM_EVT_SRC-1:0] clr_on;
  logic [NUM_EVT_SRC-1:0] clr_off;
  logic [4:0]             src;

  always_comb begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      prev_next[s*NUM_COND +: NUM_COND] = eff_flags[s];
    end
    // Status, voltage-state and difference flags all share this path
    rise = prev_next & ~prev_reg;
    fall = ~prev_next & prev_reg;
    pend_all = {pend_off_reg, pend_on_reg};
    emit = |pend_all;
    pick = first_set(pend_all);
    src     = pick_source(pick);
    clr_on  = '0;
    clr_off = '0;
    if (emit) begin
      if (pick_is_on(pick)) begin
        clr_on[src] = 1'b1;
      end else begin
        clr_off[src] = 1'b1;
      end
    end
    // New edge wins over the clear of the same source
    pend_on_next  = (pend_on_reg & ~clr_on) | (rise & i_on_select);
    pend_off_next = (pend_off_reg & ~clr_off) | (fall & i_off_select);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      prev_reg     <= '0;
      pend_on_reg  <= '0;
      pend_off_reg <= '0;
    end else begin
      prev_reg     <= prev_next;
      pend_on_reg  <= pend_on_next;
      pend_off_reg <= pend_off_next;
    end
  end

  // ----------------------------------------------------------------------
  // Event composition
  // ----------------------------------------------------------------------
  event_record_t evt_next;
  logic [1:0]    evt_stage;

  always_comb begin
    evt_stage              = 2'(src / 5'(NUM_COND));
    evt_next               = RECORD_RESET;
    evt_next.time_ms       = i_time_ms;
    evt_next.id.stage      = evt_stage;
    evt_next.id.cond       = 3'(src % 5'(NUM_COND));
    evt_next.id.is_on      = pick_is_on(pick);
    evt_next.data          = i_stage_data[evt_stage];
    evt_next.setting_group = i_setting_group;
  end

  event_record_t o_event_next;
  logic          o_event_valid_next;

  always_comb begin
    o_event_valid_next = emit;
    o_event_next       = emit ? evt_next : o_event;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_event_valid <= 1'b0;
      o_event       <= RECORD_RESET;
    end else begin
      o_event_valid <= o_event_valid_next;
      o_event       <= o_event_next;
    end
  end

  // ----------------------------------------------------------------------
  // Record store
  // ----------------------------------------------------------------------
  // Records follow the emitted stream, so a deselected edge is not kept
  event_record_t    rec_mem [NUM_RECORDS];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [3:0]       count_next;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    count_next  = o_record_count;
    if (emit) begin
      wr_ptr_next = ptr_wrap({1'b0, wr_ptr_reg} + (PTR_W+1)'(1));
      if (o_record_count < 4'(NUM_RECORDS)) begin
        count_next = o_record_count + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr_reg     <= '0;
      o_record_count <= '0;
    end else begin
      wr_ptr_reg     <= wr_ptr_next;
      o_record_count <= count_next;
    end
  end

  // Oldest slot is the one overwritten once the store is full
  always_ff @(posedge i_clock) begin
    if (emit) begin
      rec_mem[wr_ptr_reg] <= evt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read port: index 0 is the newest record
  // ----------------------------------------------------------------------
  logic [PTR_W-1:0] rd_ptr;
  logic             rd_ok;
  event_record_t    o_record_next;

  always_comb begin
    rd_ok  = (i_read_index < o_record_count);
    rd_ptr = ptr_wrap({1'b0, wr_ptr_reg} + (PTR_W+1)'(NUM_RECORDS - 1)
                      - (PTR_W+1)'(i_read_index));
    o_record_next = rd_ok ? rec_mem[rd_ptr] : RECORD_RESET;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_record       <= RECORD_RESET;
      o_record_valid <= 1'b0;
    end else begin
      o_record       <= o_record_next;
      o_record_valid <= rd_ok;
    end
  end

endmodule

// File: dv/sync_check_event_recorder_chk.sv
/* Port checker for the event recorder.
   Assumes it is bound to the recorder and sees only its ports. */
`timescale 1ns/100ps
module sync_check_event_recorder_chk #(
  parameter int unsigned NUM_RECORDS = sync_check_pkg::REC_DEPTH
) (
  input wire logic                                i_clock,
  input wire logic                                i_sys_rst,
  input wire sync_check_pkg::stage_data_t         i_stage_data [sync_check_pkg::NUM_STAGES],
  input wire logic [sync_check_pkg::TIME_W-1:0]   i_time_ms,
  input wire logic [sync_check_pkg::GROUP_W-1:0]  i_setting_group,
  input wire logic [3:0]                          i_read_index,
  input wire logic                                o_event_valid,
  input wire sync_check_pkg::event_record_t       o_event,
  input wire sync_check_pkg::event_record_t       o_record,
  input wire logic                                o_record_valid,
  input wire logic [3:0]                          o_record_count
);
  import sync_check_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ----
  // Checks
  // ----
  AST_RESET_CLEAR: assert property ($fell(i_sys_rst) |-> !o_event_valid && o_record_count == 4'h0)
    else $error("outputs not clear after reset");
  AST_COUNT_STEP: assert property (o_event_valid && !$past(i_sys_rst) |-> o_record_count ==
    (($past(o_record_count) == NUM_RECORDS) ? $past(o_record_count) : $past(o_record_count) + 4'h1))
    else $error("record count step wrong");
  AST_COUNT_HOLD: assert property (!o_event_valid && !$past(i_sys_rst) |-> $stable(o_record_count))
    else $error("record count moved without event");
  AST_EVT_HOLD: assert property (!o_event_valid && !$past(i_sys_rst) |-> $stable(o_event))
    else $error("event word changed without valid");
  AST_EVT_STAMP: assert property (o_event_valid |-> o_event.time_ms == $past(i_time_ms)
    && o_event.setting_group == $past(i_setting_group)) else $error("event stamp wrong");
  AST_EVT_DATA: assert property (o_event_valid && o_event.id.stage == 2'h1 |->
    o_event.data == $past(i_stage_data[1])) else $error("event data wrong");
  AST_EVT_STAGE: assert property (o_event_valid |-> o_event.id.stage != STAGE_NONE)
    else $error("event stage out of range");
  AST_REC_VALID: assert property (!o_event_valid && !$past(i_sys_rst) |->
    o_record_valid == ($past(i_read_index) < $past(o_record_count))) else $error("record valid wrong");
  AST_REC_ZERO: assert property (!o_record_valid |-> o_record == RECORD_RESET)
    else $error("record not zero when invalid");
  COV_BURST: cover property (o_event_valid ##1 o_event_valid);
  COV_FULL: cover property (o_record_count == 4'hc);
  COV_READ: cover property (o_record_valid);
endmodule

bind sync_check_event_recorder sync_check_event_recorder_chk #(.NUM_RECORDS(NUM_RECORDS)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_stage_data(i_stage_data), .i_time_ms(i_time_ms),
  .i_setting_group(i_setting_group), .i_read_index(i_read_index), .o_event_valid(o_event_valid),
  .o_event(o_event), .o_record(o_record), .o_record_valid(o_record_valid), .o_record_count(o_record_count));

// File: dv/testbench.sv
/* Self-checking bench for the event recorder.
   Assumes the package and the recorder are compiled first. */
`timescale 1ns/100ps
module testbench;
  import sync_check_pkg::*;
  logic          i_clock = 1'b0;
  logic          i_sys_rst = 1'b1;
  stage_flags_t  flags [NUM_STAGES] = '{default: 8'h00};
  stage_data_t   data [NUM_STAGES];
  logic          force_en = 1'b0;
  logic [2:0]    force_code = 3'h0;
  logic [23:0]   on_sel = 24'hff_ffff;
  logic [23:0]   off_sel = 24'hff_ffff;
  logic [47:0]   tstamp = 48'h0;
  logic [2:0]    group = 3'h5;
  logic [3:0]    rd_idx = 4'h0;
  logic          o_event_valid;
  logic          o_record_valid;
  event_record_t o_event;
  event_record_t o_record;
  logic [3:0]    o_record_count;
  int            n_fail = 0;
  int            checks = 0;

  sync_check_event_recorder u_dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_stage_flags(flags), .i_stage_data(data),
    .i_force_enable(force_en), .i_force_status(force_code), .i_on_select(on_sel), .i_off_select(off_sel),
    .i_time_ms(tstamp), .i_setting_group(group), .i_read_index(rd_idx), .o_event_valid(o_event_valid),
    .o_event(o_event), .o_record(o_record), .o_record_valid(o_record_valid), .o_record_count(o_record_count));

  initial begin
    foreach (data[s]) data[s] <= {17{8'(s + 8'h11)}};
    forever #12.5 i_clock = ~i_clock;
  end
  // Moving stamp shows when the event was sampled
  always @(posedge i_clock) tstamp <= tstamp + 48'h1;

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask

  task automatic expect_evt(input int s, input int c, input logic on);
    int k;
    k = 0;
    do begin
      tick();
      k++;
    end while (o_event_valid !== 1'b1 && k < 60);
    if (o_event_valid !== 1'b1) begin
      chk(1'b0, 1'b1);
      final_report();
    end else begin
      chk(o_event.id, {s[1:0], c[2:0], on});
      chk(o_event.time_ms, tstamp - 48'h1);
      chk(o_event.data, data[s]);
    end
  endtask

  task automatic no_evt(input int n);
    repeat (n) begin
      tick();
      chk(o_event_valid, 1'b0);
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_all;
    @(posedge i_clock) foreach (flags[s]) flags[s] <= 8'hff;
    for (int i = 0; i < 24; i++) expect_evt(i / 8, i % 8, 1'b1);
    no_evt(4);
    @(posedge i_clock) foreach (flags[s]) flags[s] <= 8'h00;
    for (int i = 0; i < 24; i++) expect_evt(i / 8, i % 8, 1'b0);
    chk(o_record_count, 4'hc);
    for (int i = 0; i < 13; i++) begin
      @(posedge i_clock) rd_idx <= i[3:0];
      tick();
      chk(o_record_valid, i < 12);
      if (i == 12) begin
        chk(o_record, RECORD_RESET);
      end else begin
        chk(o_record.id, {2'((23 - i) / 8), 3'((23 - i) % 8), 1'b0});
        chk(o_record.data, data[(23 - i) / 8]);
        chk(o_record.setting_group, group);
      end
    end
  endtask

  task automatic t_select;
    @(posedge i_clock) on_sel <= 24'h00_0000;
    off_sel <= 24'h00_0002;
    flags[0][1] <= 1'b1;
    no_evt(6);
    @(posedge i_clock) flags[0][1] <= 1'b0;
    expect_evt(0, 1, 1'b0);
    @(posedge i_clock) on_sel <= 24'hff_ffff;
    off_sel <= 24'hff_ffff;
  endtask

  task automatic t_force;
    @(posedge i_clock) force_en <= 1'b1;
    for (int k = 1; k < 7; k++) begin
      @(posedge i_clock) force_code <= k[2:0];
      expect_evt((k - 1) / 2, 1 - k % 2, 1'b1);
      @(posedge i_clock) force_code <= 3'h0;
      expect_evt((k - 1) / 2, 1 - k % 2, 1'b0);
    end
    @(posedge i_clock) force_code <= 3'h7;
    no_evt(5);
  endtask

  // Mid-run reset drops a queued edge; the still-high flag rises again after release
  task automatic t_reset;
    @(posedge i_clock) flags[2][3] <= 1'b1;
    @(posedge i_clock) i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd_idx <= 4'h0;
    tick();
    chk(o_record_count, 4'h0);
    chk(o_record_valid, 1'b0);
    expect_evt(2, 3, 1'b1);
    chk(o_record_count, 4'h1);
    tick();
    chk(o_record_valid, 1'b1);
    chk(o_record.id, {2'h2, 3'h3, 1'b1});
  endtask

  initial begin
    repeat (8) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    tick();
    chk(o_record_count, 4'h0);
    t_all();
    t_select();
    t_force();
    t_reset();
    final_report();
  end
endmodule
